// ### rtl/fcr_fault_regs.sv
// Fault flag register bank: first fault register bits 0..2 and the second
// fault register. Assumes a byte-wide register port from the serial
// management slave, one-cycle strobes, all inputs synchronous to i_clk_sys.
//
// Behaviour
// - Second fault register at 0x0B, reserved bits zero
// - First register bit 0: boost rail overvoltage
// - Latched mode: set, hold, read clears, reassert
// - Latch disabled: bit mirrors live fault only
// - Bit reads 0 without fault since clear
// - Second register bit 4: buffer undervoltage, reset 0
// - Second register bit 3: buffer overvoltage, reset 0
// - Bit 1 thermal shutdown, reasserts after clearing read
// - Thermal flag 0 without event, 1 during shutdown
// - Bit 0 reset indicator: 1 after reset, read-clear
// - First register bits 1,2: boost undervolt, overload
module fcr_fault_regs
  import fcr_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Register port
  input wire logic i_rd_stb,
  input wire logic i_wr_stb,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  // Fault behaviour setting
  input wire logic i_fault_latch_dis,
  // Fault levels from the analog comparators
  input wire logic i_boost_rail_overvolt,
  input wire logic i_boost_rail_undervolt,
  input wire logic i_output_overload,
  input wire logic i_common_buffer_overvolt,
  input wire logic i_common_buffer_undervolt,
  input wire logic i_thermal_shutdown
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks: the offsets need 8 address bits, the fields 8 data bits
  if (ADDR_W != 8) begin : g_bad_addr
    $error("fcr_fault_regs: ADDR_W must be 8");
  end
  if (DATA_W != 8) begin : g_bad_data
    $error("fcr_fault_regs: DATA_W must be 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic power_on_reset_indicator;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } fcr_state_type;

  fcr_state_type state;
  fcr_state_type next_state;

  // Address match, used by both the read and the write decode
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = (addr == ofs[ADDR_W-1:0]);
  endfunction

  // Clear request for one bit: clearing read of its register or a 0 written
  function automatic logic bit_clear(input logic rd, input logic wr,
                                     input logic hit, input logic wbit);
    bit_clear = hit & (rd | (wr & ~wbit));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic hit_one;
  logic hit_two;
  logic [FCR_NUM_SRC-1:0] fault_in;
  logic [FCR_NUM_SRC-1:0] clear_req;
  logic [FCR_NUM_SRC-1:0] flag_val;
  logic [DATA_W-1:0] view_one;
  logic [DATA_W-1:0] view_two;

  assign hit_one = reg_hit(i_addr, FCR_OFS_FAULT_ONE);
  assign hit_two = reg_hit(i_addr, FCR_OFS_FAULT_TWO);

  // Fault sources in cell order
  assign fault_in[FCR_SRC_BOOST_OV] = i_boost_rail_overvolt;
  assign fault_in[FCR_SRC_BOOST_UV] = i_boost_rail_undervolt;
  assign fault_in[FCR_SRC_OUT_OVLD] = i_output_overload;
  assign fault_in[FCR_SRC_COMMON_BUFFER_OVERVOLT_FLAG] = i_common_buffer_overvolt;
  assign fault_in[FCR_SRC_COMMON_BUFFER_UNDERVOLT_FLAG] = i_common_buffer_undervolt;
  assign fault_in[FCR_SRC_THERM] = i_thermal_shutdown;

  // Clears: a read clears the whole register, a write only its 0 bits
  assign clear_req[FCR_SRC_BOOST_OV] =
    bit_clear(i_rd_stb, i_wr_stb, hit_one, i_wdata[FCR_B1_BOOST_OV]);
  assign clear_req[FCR_SRC_BOOST_UV] =
    bit_clear(i_rd_stb, i_wr_stb, hit_one, i_wdata[FCR_B1_BOOST_UV]);
  assign clear_req[FCR_SRC_OUT_OVLD] =
    bit_clear(i_rd_stb, i_wr_stb, hit_one, i_wdata[FCR_B1_OUT_OVLD]);
  assign clear_req[FCR_SRC_COMMON_BUFFER_OVERVOLT_FLAG] =
    bit_clear(i_rd_stb, i_wr_stb, hit_two, i_wdata[FCR_B2_COMMON_BUFFER_OVERVOLT_FLAG]);
  assign clear_req[FCR_SRC_COMMON_BUFFER_UNDERVOLT_FLAG] =
    bit_clear(i_rd_stb, i_wr_stb, hit_two, i_wdata[FCR_B2_COMMON_BUFFER_UNDERVOLT_FLAG]);
  assign clear_req[FCR_SRC_THERM] =
    bit_clear(i_rd_stb, i_wr_stb, hit_two, i_wdata[FCR_B2_THERM]);

  ////////////////////////////////////////////////////////////////////////////
  // One flag cell per fault source; all share the latch-disable setting
  for (genvar g = 0; g < FCR_NUM_SRC; g++) begin : g_cell
    fcr_flag_cell u_cell (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_latch_dis(i_fault_latch_dis),
      .i_fault(fault_in[g]),
      .i_clear(clear_req[g]),
      .o_value(flag_val[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register views; bits owned by other blocks and reserved bits read 0
  always_comb begin
    view_one = '0;
    view_one[FCR_B1_BOOST_OV] = flag_val[FCR_SRC_BOOST_OV];
    view_one[FCR_B1_BOOST_UV] = flag_val[FCR_SRC_BOOST_UV];
    view_one[FCR_B1_OUT_OVLD] = flag_val[FCR_SRC_OUT_OVLD];
  end

  always_comb begin
    view_two = '0;
    view_two[FCR_B2_POR_IND] = state.power_on_reset_indicator;
    view_two[FCR_B2_THERM] = flag_val[FCR_SRC_THERM];
    view_two[FCR_B2_COMMON_BUFFER_OVERVOLT_FLAG] = flag_val[FCR_SRC_COMMON_BUFFER_OVERVOLT_FLAG];
    view_two[FCR_B2_COMMON_BUFFER_UNDERVOLT_FLAG] = flag_val[FCR_SRC_COMMON_BUFFER_UNDERVOLT_FLAG];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read capture and reset indicator. The value returned is the one before
  // the clear takes effect, so a read never loses an event it reports.
  always_comb begin
    next_state = state;
    next_state.rvalid = i_rd_stb;
    if (i_rd_stb) begin
      if (hit_one) begin
        next_state.rdata = view_one;
      end else if (hit_two) begin
        next_state.rdata = view_two;
      end else begin
        next_state.rdata = FCR_READ_UNMAPPED[DATA_W-1:0];
      end
    end
    // Only a read clears it; writes cannot touch a read-only bit
    if (i_rd_stb && hit_two) begin
      next_state.power_on_reset_indicator = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state.power_on_reset_indicator <= FCR_RST_POR_IND;
      state.rdata <= FCR_RST_RDATA[DATA_W-1:0];
      state.rvalid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata = state.rdata;
  assign o_rvalid = state.rvalid;

endmodule

// ### shared/fcr_pkg.sv
// Constants for the fault flag register bank: offsets, bit positions and
// reset values. Assumes an 8-bit register space reached by a byte-wide port.
package fcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] FCR_OFS_FAULT_ONE = 8'h0a;
  localparam logic [7:0] FCR_OFS_FAULT_TWO = 8'h0b;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in the first fault register
  localparam int FCR_B1_BOOST_OV = 0;
  localparam int FCR_B1_BOOST_UV = 1;
  localparam int FCR_B1_OUT_OVLD = 2;

  // Field positions in the second fault register
  localparam int FCR_B2_POR_IND = 0;
  localparam int FCR_B2_THERM = 1;
  localparam int FCR_B2_COMMON_BUFFER_OVERVOLT_FLAG = 3;
  localparam int FCR_B2_COMMON_BUFFER_UNDERVOLT_FLAG = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Index of each fault source in the flag cell vector
  localparam int FCR_SRC_BOOST_OV = 0;
  localparam int FCR_SRC_BOOST_UV = 1;
  localparam int FCR_SRC_OUT_OVLD = 2;
  localparam int FCR_SRC_COMMON_BUFFER_OVERVOLT_FLAG = 3;
  localparam int FCR_SRC_COMMON_BUFFER_UNDERVOLT_FLAG = 4;
  localparam int FCR_SRC_THERM = 5;
  localparam int FCR_NUM_SRC = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic FCR_RST_FLAG = 1'b0;
  localparam logic FCR_RST_POR_IND = 1'b1;
  localparam logic [7:0] FCR_RST_RDATA = 8'h00;
  localparam logic [7:0] FCR_READ_UNMAPPED = 8'h00;

endpackage

// ### rtl/fcr_flag_cell.sv
// One fault bit: live status or latched flag, chosen by the latch-disable level.
// Assumes the fault level and the clear pulse are synchronous to i_clk_sys.
module fcr_flag_cell
  import fcr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_latch_dis,
  input wire logic i_fault,
  input wire logic i_clear,
  output logic o_value
);

  typedef struct packed {
    logic flag;
  } fcr_cell_state_type;

  fcr_cell_state_type state;
  fcr_cell_state_type next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Set wins over clear, so a persisting fault reasserts at once after a clear
  always_comb begin
    next_state = state;
    if (i_latch_dis) begin
      next_state.flag = i_fault;
    end else begin
      next_state.flag = i_fault | (state.flag & ~i_clear);
    end
  end

  // Flag register
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state.flag <= FCR_RST_FLAG;
    end else begin
      state <= next_state;
    end
  end

  // Live mode shows the fault as it stands now, latched mode the held flag
  assign o_value = i_latch_dis ? i_fault : state.flag;

endmodule

// ### test/fcr_fault_regs_assertions.sv
// Checker for the fault register port: answers, reserved bits, flags.
// Assumes the bank is built with 8-bit address and data.
module fcr_chk
  import fcr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_rd_stb,
  input wire logic i_wr_stb,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_fault_latch_dis,
  input wire logic i_boost_rail_overvolt,
  input wire logic i_boost_rail_undervolt,
  input wire logic i_output_overload,
  input wire logic i_common_buffer_overvolt,
  input wire logic i_common_buffer_undervolt,
  input wire logic i_thermal_shutdown
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////
  // Read decodes, and whether the indicator was read since reset
  logic r_a, r_b, rd_seen;
  assign r_a = i_rd_stb && i_addr == FCR_OFS_FAULT_ONE;
  assign r_b = i_rd_stb && i_addr == FCR_OFS_FAULT_TWO;
  always_ff @(posedge i_clk_sys) begin
    rd_seen <= i_nrst && (rd_seen || r_b);
  end
  property p_rv; i_rd_stb |=> o_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_rsv; r_b |=> (o_rdata & 8'he4) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_unm; i_rd_stb && !r_a && !r_b |=> o_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_live; r_a && i_fault_latch_dis |=> o_rdata[2:0] ==
    $past({i_output_overload, i_boost_rail_undervolt, i_boost_rail_overvolt}); endproperty
  a_live: assert property (p_live) else $error("live bits");
  property p_lat; r_b && !i_fault_latch_dis && $past(i_common_buffer_undervolt)
    && $past(i_nrst) |=> o_rdata[4]; endproperty
  a_lat: assert property (p_lat) else $error("flag lost");
  // Flag must survive the clearing read while the shutdown persists
  property p_th; (r_b && i_thermal_shutdown) ##1 (!i_wr_stb && !i_fault_latch_dis)
    ##1 (r_b && !i_fault_latch_dis) |=> o_rdata[1]; endproperty
  a_th: assert property (p_th) else $error("no reassert");
  property p_clr; (r_b && !i_common_buffer_overvolt) ##1 !i_common_buffer_overvolt
    ##1 (r_b && !i_common_buffer_overvolt) |=> !o_rdata[3]; endproperty
  a_clr: assert property (p_clr) else $error("stale flag");
  property p_por; r_b |=> o_rdata[0] == !$past(rd_seen); endproperty
  a_por: assert property (p_por) else $error("reset indicator");
  c_two: cover property (r_b ##2 r_b);
  c_live: cover property (r_a && i_fault_latch_dis);
  c_th: cover property (r_b && i_thermal_shutdown);
endmodule
bind fcr_fault_regs fcr_chk i_fcr_chk (.i_clk_sys, .i_nrst, .i_rd_stb, .i_wr_stb,
  .i_addr, .o_rdata, .o_rvalid, .i_fault_latch_dis, .i_boost_rail_overvolt,
  .i_boost_rail_undervolt, .i_output_overload, .i_common_buffer_overvolt,
  .i_common_buffer_undervolt, .i_thermal_shutdown);

// ### test/tb.sv
// Testbench for the fault register bank: reads, writes, fault pulses.
// Assumes the checker is bound from its own file.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 0, i_nrst = 0, rd = 0, wr = 0, ld = 0, o_rvalid;
  logic [7:0] ad = 8'h00, wd = 8'h00, o_rdata;
  logic [5:0] f = 6'h00;
  int errors = 0, check_count = 0;
  fcr_fault_regs i_fcr_fault_regs (.i_clk_sys, .i_nrst, .i_rd_stb(rd), .i_wr_stb(wr),
    .i_addr(ad), .i_wdata(wd), .o_rdata, .o_rvalid, .i_fault_latch_dis(ld),
    .i_boost_rail_overvolt(f[0]), .i_boost_rail_undervolt(f[1]),
    .i_output_overload(f[2]), .i_common_buffer_overvolt(f[3]),
    .i_common_buffer_undervolt(f[4]), .i_thermal_shutdown(f[5]));
  initial forever #5 i_clk_sys = ~i_clk_sys;
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // One idle cycle between requests keeps reads two cycles apart
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    rd <= 1'b1;
    ad <= a;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    @(negedge i_clk_sys);
    chk(8'h01, {7'h00, o_rvalid});
    chk(e, o_rdata);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    wr <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge i_clk_sys);
    f <= v;
    @(posedge i_clk_sys);
    f <= 6'h00;
  endtask
  ////////////////////////////////////////
  task automatic t_por();
    rdc(8'h0b, 8'h01);
    rdc(8'h0b, 8'h00);
    rdc(8'h0a, 8'h00);
    rdc(8'h0c, 8'h00);
  endtask
  task automatic t_lat();
    pulse(6'h3f);
    rdc(8'h0a, 8'h07);
    rdc(8'h0a, 8'h00);
    rdc(8'h0b, 8'h1a);
    rdc(8'h0b, 8'h00);
  endtask
  task automatic t_hold();
    @(posedge i_clk_sys);
    f <= 6'h30;
    rdc(8'h0b, 8'h12);
    rdc(8'h0b, 8'h12);
    @(posedge i_clk_sys);
    f <= 6'h00;
    rdc(8'h0b, 8'h12);
    rdc(8'h0b, 8'h00);
  endtask
  // Writes of one must not clear; the indicator ignores writes
  task automatic t_wr();
    pulse(6'h18);
    wrc(8'h0b, 8'hf7);
    rdc(8'h0b, 8'h10);
    pulse(6'h03);
    wrc(8'h0a, 8'hfe);
    rdc(8'h0a, 8'h02);
    wrc(8'h0b, 8'hff);
    rdc(8'h0b, 8'h00);
  endtask
  task automatic t_live();
    @(posedge i_clk_sys);
    ld <= 1'b1;
    f <= 6'h12;
    rdc(8'h0a, 8'h02);
    rdc(8'h0b, 8'h10);
    @(posedge i_clk_sys);
    f <= 6'h00;
    rdc(8'h0a, 8'h00);
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    t_por();
    t_lat();
    t_hold();
    t_wr();
    t_live();
    stop_test();
  end
  // Whole run is under a hundred cycles
  initial begin
    #20000;
    errors++;
    stop_test();
  end
endmodule
